//--- rtl/host_bus_if.sv
// Pin-level interface between the processor and the USB controller port
`timescale 1ns/1ps
`default_nettype none
interface host_bus_if;
    logic chipSelectN;
    logic readStrobeN;
    logic writeStrobeN;
    logic pointerOrDataSelect;
    logic [7:0] hostData;
    logic hostDataOeN;
    logic [7:0] devData;
    logic devDataOeN;
    logic dmaAckN;
    logic dmaReqN;
    logic irqOut;
    logic resetInN;
    logic masterSlaveStrap;
    logic clockMultiplyStrap;
    logic [7:0] busData;
    assign busData = !devDataOeN ? devData :
        (!hostDataOeN ? hostData : 8'hff);
    modport device (
        input chipSelectN, readStrobeN, writeStrobeN, pointerOrDataSelect,
        input busData, dmaAckN, resetInN, masterSlaveStrap,
        input clockMultiplyStrap,
        output devData, devDataOeN, dmaReqN, irqOut
    );
    modport host (
        output chipSelectN, readStrobeN, writeStrobeN, pointerOrDataSelect,
        output hostData, hostDataOeN, dmaAckN, resetInN, masterSlaveStrap,
        output clockMultiplyStrap,
        input busData, dmaReqN, irqOut
    );
endinterface
`default_nettype wire

//--- rtl/host_bus_pkg.sv
// Shared constants for the parallel host bus port
package host_bus_pkg;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 256;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic SEL_POINTER = 1'b0;
    localparam logic SEL_DATA = 1'b1;
    localparam logic MODE_SLAVE = 1'b1;
    localparam logic MODE_HOST = 1'b0;
    localparam logic CLK_12MHZ = 1'b1;
    localparam logic CLK_48MHZ = 1'b0;
    // Host strobe phases, in clk cycles
    localparam int SETUP_CYCLES = 3;
    localparam int STROBE_CYCLES = 8;
    localparam int HOLD_CYCLES = 6;
endpackage

//--- rtl/usb_ctrl_host_bus_port.sv
// Device end of the parallel processor port
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_host_bus_port
    import host_bus_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    input wire logic clk,
    input wire logic reset_in_n,
    host_bus_if.device bus,
    input wire logic dmaWant,
    input wire logic irqPending,
    output logic slaveMode,
    output logic mult12Mhz,
    output logic dmaActive,
    output logic writePulse,
    output logic [7:0] writeAddr,
    output logic [7:0] writeData
);
    // ==========================================
    // Pin synchronisers
    logic [2:0] csSync, rdSync, wrSync, selSync, ackSync, rstSync, msSync;
    logic [2:0] cmSync;
    logic [7:0] dSync1, dSync2;
    logic [2:0] csNext, rdNext, wrNext, selNext, ackNext, rstNext, msNext;
    logic [2:0] cmNext;
    always_comb begin
        csNext = {csSync[1:0], bus.chipSelectN};
        rdNext = {rdSync[1:0], bus.readStrobeN};
        wrNext = {wrSync[1:0], bus.writeStrobeN};
        selNext = {selSync[1:0], bus.pointerOrDataSelect};
        ackNext = {ackSync[1:0], bus.dmaAckN};
        rstNext = {rstSync[1:0], bus.resetInN};
        msNext = {msSync[1:0], bus.masterSlaveStrap};
        cmNext = {cmSync[1:0], bus.clockMultiplyStrap};
    end
    always_ff @(posedge clk) begin
        if (!reset_in_n) begin
            csSync <= 3'h7;
            rdSync <= 3'h7;
            wrSync <= 3'h7;
            selSync <= 3'h0;
            ackSync <= 3'h7;
            rstSync <= 3'h0;
            msSync <= 3'h0;
            cmSync <= 3'h0;
            dSync1 <= 8'h00;
            dSync2 <= 8'h00;
        end else begin
            csSync <= csNext;
            rdSync <= rdNext;
            wrSync <= wrNext;
            selSync <= selNext;
            ackSync <= ackNext;
            rstSync <= rstNext;
            msSync <= msNext;
            cmSync <= cmNext;
            dSync1 <= bus.busData;
            dSync2 <= dSync1;
        end
    end

    // ==========================================
    // Filtered levels
    logic csF_reg, rdF_reg, wrF_reg, selF_reg, ackF_reg, rstF_reg;
    logic msF_reg, cmF_reg;
    logic csF_next, rdF_next, wrF_next, selF_next, ackF_next, rstF_next;
    logic msF_next, cmF_next;
    always_comb begin
        csF_next = (csSync[1] == csSync[2]) ? csSync[2] : csF_reg;
        rdF_next = (rdSync[1] == rdSync[2]) ? rdSync[2] : rdF_reg;
        wrF_next = (wrSync[1] == wrSync[2]) ? wrSync[2] : wrF_reg;
        selF_next = (selSync[1] == selSync[2]) ? selSync[2] : selF_reg;
        ackF_next = (ackSync[1] == ackSync[2]) ? ackSync[2] : ackF_reg;
        rstF_next = (rstSync[1] == rstSync[2]) ? rstSync[2] : rstF_reg;
        msF_next = (msSync[1] == msSync[2]) ? msSync[2] : msF_reg;
        cmF_next = (cmSync[1] == cmSync[2]) ? cmSync[2] : cmF_reg;
    end
    always_ff @(posedge clk) begin
        if (!reset_in_n) begin
            csF_reg <= 1'b1;
            rdF_reg <= 1'b1;
            wrF_reg <= 1'b1;
            selF_reg <= 1'b0;
            ackF_reg <= 1'b1;
            rstF_reg <= 1'b0;
            msF_reg <= 1'b0;
            cmF_reg <= 1'b0;
        end else begin
            csF_reg <= csF_next;
            rdF_reg <= rdF_next;
            wrF_reg <= wrF_next;
            selF_reg <= selF_next;
            ackF_reg <= ackF_next;
            rstF_reg <= rstF_next;
            msF_reg <= msF_next;
            cmF_reg <= cmF_next;
        end
    end

    // ==========================================
    // Access state
    logic [7:0] mem [DEPTH];
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] rdData_reg, rdData_next;
    logic wrHeld_reg, wrHeld_next;
    logic readOe_reg, readOe_next;
    logic dmaReqN_reg, dmaReqN_next;
    logic irq_reg, irq_next;
    logic [7:0] wAddr_reg, wAddr_next, wData_reg, wData_next;
    logic wPulse_reg, wPulse_next;
    logic mode_reg, mode_next, cm_reg, cm_next;
    logic devReset, cycleWrite, cycleRead, dmaCycle, dmaOk;

    always_comb begin
        // Device held in reset while reset pin is low
        // pin reset
        devReset = !rstF_reg;
        mode_next = devReset ? msF_reg : mode_reg;
        cm_next = devReset ? cmF_reg : cm_reg;
        dmaOk = (mode_reg == MODE_SLAVE);
        dmaCycle = dmaOk && !ackF_reg;
        cycleWrite = !wrF_reg && (!csF_reg || dmaCycle);
        cycleRead = !rdF_reg && (!csF_reg || dmaCycle);
        wrHeld_next = cycleWrite;
        ptr_next = ptr_reg;
        wPulse_next = 1'b0;
        wAddr_next = wAddr_reg;
        wData_next = wData_reg;
        if (cycleWrite && !wrHeld_reg) begin
            if (selF_reg == SEL_POINTER && !dmaCycle) begin
                ptr_next = dSync2;
            end else begin
                wPulse_next = 1'b1;
                wAddr_next = ptr_reg;
                wData_next = dSync2;
            end
        end
        rdData_next = mem[ptr_reg];
        readOe_next = cycleRead;
        dmaReqN_next = !(dmaOk && dmaWant);
        irq_next = irqPending;
        if (devReset) begin
            ptr_next = PTR_RESET;
            wPulse_next = 1'b0;
            readOe_next = 1'b0;
            dmaReqN_next = 1'b1;
            irq_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (wPulse_reg) begin
            mem[wAddr_reg] <= wData_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_in_n) begin
            ptr_reg <= PTR_RESET;
            rdData_reg <= DATA_RESET;
            wrHeld_reg <= 1'b0;
            readOe_reg <= 1'b0;
            dmaReqN_reg <= 1'b1;
            irq_reg <= 1'b0;
            wAddr_reg <= 8'h00;
            wData_reg <= 8'h00;
            wPulse_reg <= 1'b0;
            mode_reg <= MODE_HOST;
            cm_reg <= CLK_48MHZ;
        end else begin
            ptr_reg <= ptr_next;
            rdData_reg <= rdData_next;
            wrHeld_reg <= wrHeld_next;
            readOe_reg <= readOe_next;
            dmaReqN_reg <= dmaReqN_next;
            irq_reg <= irq_next;
            wAddr_reg <= wAddr_next;
            wData_reg <= wData_next;
            wPulse_reg <= wPulse_next;
            mode_reg <= mode_next;
            cm_reg <= cm_next;
        end
    end

    assign bus.devData = rdData_reg;
    assign bus.devDataOeN = !readOe_reg;
    assign bus.dmaReqN = dmaReqN_reg;
    assign bus.irqOut = irq_reg;
    assign slaveMode = mode_reg;
    assign mult12Mhz = cm_reg;
    assign dmaActive = dmaCycle;
    assign writePulse = wPulse_reg;
    assign writeAddr = wAddr_reg;
    assign writeData = wData_reg;
endmodule
`default_nettype wire

//--- rtl/usb_ctrl_host_side.sv
// Processor end driving the parallel port strobes
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_host_side
    import host_bus_pkg::*;
(
    input wire logic clk,
    input wire logic reset_in_n,
    host_bus_if.host bus,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqSel,
    input wire logic [7:0] reqData,
    output logic reqReady,
    output logic [7:0] rspData,
    output logic rspValid,
    input wire logic resetDevice,
    input wire logic slaveStrap,
    input wire logic clk12Strap,
    input wire logic dmaAckIn,
    output logic dmaReqSeen,
    output logic irqSeen
);
    typedef enum logic [1:0] {
        IDLE = 2'b00, SETUP = 2'b01, STROBE = 2'b10, HOLD = 2'b11
    } phase_e;
    // ==========================================
    // Strobe sequencer
    phase_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next, sel_reg, sel_next;
    logic [7:0] d_reg, d_next, rsp_reg, rsp_next;
    logic rv_reg, rv_next;
    logic [2:0] drqS, irqS;
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        sel_next = sel_reg;
        d_next = d_reg;
        rsp_next = rsp_reg;
        rv_next = 1'b0;
        unique case (state_reg)
            IDLE: begin
                if (reqValid) begin
                    wr_next = reqWrite;
                    sel_next = reqSel;
                    d_next = reqData;
                    cnt_next = 4'(SETUP_CYCLES - 1);
                    state_next = SETUP;
                end
            end
            SETUP: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h0) begin
                    cnt_next = 4'(STROBE_CYCLES - 1);
                    state_next = STROBE;
                end
            end
            STROBE: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h0) begin
                    rsp_next = bus.busData;
                    rv_next = !wr_reg;
                    cnt_next = 4'(HOLD_CYCLES - 1);
                    state_next = HOLD;
                end
            end
            HOLD: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h0) begin
                    state_next = IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!reset_in_n) begin
            state_reg <= IDLE;
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            sel_reg <= SEL_POINTER;
            d_reg <= 8'h00;
            rsp_reg <= 8'h00;
            rv_reg <= 1'b0;
            drqS <= 3'h7;
            irqS <= 3'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            sel_reg <= sel_next;
            d_reg <= d_next;
            rsp_reg <= rsp_next;
            rv_reg <= rv_next;
            drqS <= {drqS[1:0], bus.dmaReqN};
            irqS <= {irqS[1:0], bus.irqOut};
        end
    end
    logic active;
    assign active = (state_reg != IDLE);
    assign reqReady = !active;
    assign rspData = rsp_reg;
    assign rspValid = rv_reg;
    assign bus.chipSelectN = !active;
    assign bus.writeStrobeN = !(state_reg == STROBE && wr_reg);
    assign bus.readStrobeN = !(state_reg == STROBE && !wr_reg);
    assign bus.pointerOrDataSelect = sel_reg;
    assign bus.hostData = d_reg;
    assign bus.hostDataOeN = !(active && wr_reg);
    assign bus.dmaAckN = !(slaveStrap && dmaAckIn);
    assign bus.resetInN = !resetDevice;
    assign bus.masterSlaveStrap = slaveStrap;
    assign bus.clockMultiplyStrap = clk12Strap ? CLK_12MHZ : CLK_48MHZ;
    assign dmaReqSeen = (drqS[2] == drqS[1]) && !drqS[2];
    assign irqSeen = (irqS[2] == irqS[1]) && irqS[2];
endmodule
`default_nettype wire

//--- tb/host_bus_props.sv
// Interface checker for the parallel host bus port
`timescale 1ns/1ps
`default_nettype none
module host_bus_props (
    input wire logic clk,
    input wire logic reset_in_n,
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic hostDataOeN,
    input wire logic devDataOeN,
    input wire logic dmaAckN,
    input wire logic dmaReqN,
    input wire logic irqOut,
    input wire logic resetInN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_in_n);
    // ========================================
    // Strobes, data drive and pin reset
    a_write_needs_cs: assert property (!writeStrobeN |-> !chipSelectN)
        else $error("write strobe without chip select");
    a_read_needs_cs: assert property (!readStrobeN |-> !chipSelectN)
        else $error("read strobe without chip select");
    a_write_data_on: assert property (!writeStrobeN |-> !hostDataOeN)
        else $error("host data not driven during write");
    a_write_width: assert property ($fell(writeStrobeN) |=>
        !writeStrobeN[*7] ##1 writeStrobeN)
        else $error("write strobe width wrong");
    a_read_answered: assert property ($fell(readStrobeN) && !chipSelectN
        |-> ##[1:12] !devDataOeN)
        else $error("device never drove read data");
    a_dev_drive_qual: assert property (!devDataOeN
        |-> (!chipSelectN || !dmaAckN) && hostDataOeN)
        else $error("device drives bus outside a read");
    a_strobe_excl: assert property (!(!readStrobeN && !writeStrobeN))
        else $error("read and write strobes together");
    a_pin_reset_quiet: assert property (!resetInN[*8]
        |-> !irqOut && dmaReqN && devDataOeN)
        else $error("outputs active during pin reset");
    // ========================================
    // Coverage
    c_write: cover property ($fell(writeStrobeN));
    c_read: cover property ($fell(readStrobeN));
    c_irq: cover property ($rose(irqOut));
    c_dma: cover property ($fell(dmaReqN));
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench joining both ends of the host bus port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import host_bus_pkg::*;
    typedef struct {logic rd; logic [7:0] ptr; logic [7:0] dat;} row_s;
    logic clk, reset_in_n, dmaWant, irqPending, slaveMode, mult12Mhz, dmaActive;
    logic writePulse, reqValid, reqWrite, reqSel, reqReady, rspValid;
    logic resetDevice, slaveStrap, clk12Strap, dmaAckIn, dmaReqSeen, irqSeen;
    logic [7:0] writeAddr, writeData, reqData, rspData;
    int errorCnt = 0;
    int numChecks = 0;
    row_s rows [5] = '{'{1'h0, 8'h10, 8'ha5}, '{1'h0, 8'h11, 8'h5a},
        '{1'h1, 8'h10, 8'ha5}, '{1'h1, 8'h11, 8'h5a}, '{1'h0, 8'hff, 8'h3c}};
    host_bus_if busIf();
    usb_ctrl_host_bus_port #(.DEPTH(MEM_DEPTH)) u_usb_ctrl_host_bus_port (
        .clk(clk), .reset_in_n(reset_in_n), .bus(busIf.device), .dmaWant(dmaWant),
        .irqPending(irqPending), .slaveMode(slaveMode),
        .mult12Mhz(mult12Mhz), .dmaActive(dmaActive),
        .writePulse(writePulse), .writeAddr(writeAddr),
        .writeData(writeData));
    usb_ctrl_host_side u_usb_ctrl_host_side (
        .clk(clk), .reset_in_n(reset_in_n), .bus(busIf.host), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqSel(reqSel), .reqData(reqData),
        .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid),
        .resetDevice(resetDevice), .slaveStrap(slaveStrap),
        .clk12Strap(clk12Strap), .dmaAckIn(dmaAckIn),
        .dmaReqSeen(dmaReqSeen), .irqSeen(irqSeen));
    host_bus_props u_host_bus_props (
        .clk(clk), .reset_in_n(reset_in_n), .chipSelectN(busIf.chipSelectN),
        .readStrobeN(busIf.readStrobeN), .writeStrobeN(busIf.writeStrobeN),
        .hostDataOeN(busIf.hostDataOeN), .devDataOeN(busIf.devDataOeN),
        .dmaAckN(busIf.dmaAckN), .dmaReqN(busIf.dmaReqN),
        .irqOut(busIf.irqOut), .resetInN(busIf.resetInN));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // ========================================
    // Helpers
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    task automatic finalReport;
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic waitLvl(input int k, input logic lvl);
        int n;
        logic s;
        n = 0;
        s = ~lvl;
        while (s !== lvl && n < 60) begin
            case (k)
                0: s = writePulse;
                1: s = rspValid;
                2: s = irqSeen;
                3: s = dmaReqSeen;
                4: s = dmaActive;
                default: s = reqReady;
            endcase
            if (s !== lvl) begin
                tick();
            end
            n++;
        end
        if (s !== lvl) begin
            errorCnt++;
            finalReport();
        end
    endtask
    task automatic req(input logic wr, input logic sel, input logic [7:0] d);
        waitLvl(5, 1'h1);
        reqValid = 1'h1;
        reqWrite = wr;
        reqSel = sel;
        reqData = d;
        tick();
        reqValid = 1'h0;
    endtask
    task automatic pinReset;
        resetDevice = 1'h1;
        repeat (10) tick();
        resetDevice = 1'h0;
        repeat (10) tick();
    endtask
    // ========================================
    // Main sequence
    initial begin
        reset_in_n = 1'h0;
        reqValid = 1'h0;
        reqWrite = 1'h0;
        reqSel = 1'h0;
        reqData = 8'h00;
        dmaWant = 1'h0;
        irqPending = 1'h0;
        resetDevice = 1'h0;
        slaveStrap = MODE_HOST;
        clk12Strap = CLK_12MHZ;
        dmaAckIn = 1'h0;
        repeat (5) tick();
        reset_in_n = 1'h1;
        tick();
        check({7'h00, reqReady}, 8'h01);
        pinReset();
        check({7'h00, slaveMode}, {7'h00, MODE_HOST});
        check({7'h00, mult12Mhz}, {7'h00, CLK_12MHZ});
        foreach (rows[i]) begin
            req(1'h1, SEL_POINTER, rows[i].ptr);
            req(~rows[i].rd, SEL_DATA, rows[i].dat);
            waitLvl(rows[i].rd ? 1 : 0, 1'h1);
            if (rows[i].rd) begin
                check(rspData, rows[i].dat);
            end else begin
                check(writeAddr, rows[i].ptr);
                check(writeData, rows[i].dat);
            end
        end
        irqPending = 1'h1;
        waitLvl(2, 1'h1);
        check({7'h00, busIf.irqOut}, 8'h01);
        irqPending = 1'h0;
        waitLvl(2, 1'h0);
        dmaWant = 1'h1;
        dmaAckIn = 1'h1;
        repeat (12) tick();
        check({7'h00, dmaActive}, 8'h00);
        check({7'h00, busIf.dmaAckN}, 8'h01);
        check({7'h00, dmaReqSeen}, 8'h00);
        dmaAckIn = 1'h0;
        slaveStrap = MODE_SLAVE;
        clk12Strap = CLK_48MHZ;
        pinReset();
        check({7'h00, slaveMode}, {7'h00, MODE_SLAVE});
        check({7'h00, mult12Mhz}, {7'h00, CLK_48MHZ});
        waitLvl(3, 1'h1);
        dmaAckIn = 1'h1;
        waitLvl(4, 1'h1);
        dmaAckIn = 1'h0;
        dmaWant = 1'h0;
        waitLvl(4, 1'h0);
        waitLvl(3, 1'h0);
        reset_in_n = 1'h0;
        repeat (2) tick();
        reset_in_n = 1'h1;
        tick();
        check({7'h00, slaveMode}, {7'h00, MODE_HOST});
        finalReport();
    end
endmodule
`default_nettype wire
